// ---- hdl/vdc_defines.vh ----
// register map, field positions, reset values and timing counts of the digitizer control
// Contract
// R1 - charge pump code bits 4-2 pick eight currents, 50 uA up to 1500 uA
// R2 - vco band bits 6-5: 00/01 low, 10 mid, 11 high range
// R3 - host writes zero to reserved bits 7-5 and bit 0 of register 0x0d
// R4 - die revision bits 3-1 are read only; writes ignored
// R5 - port sample order: 0 even to A odd to B, 1 the reverse
// R6 - host writes 0x00 to the test register after power-up
// R7 - test register access gets no acknowledge from the device
// R8 - clamp source select picks internal pulse or external clamp pin
// R9 - source 0 uses internal pulse from hsync, 1 uses external pin
// R10 - internal pulse position from clamp delay, duration from clamp width
// R11 - pulse starts delay pixels after hsync trailing edge, lasts width pixels
// R12 - ext clamp polarity bit selects active level of external clamp pin
// R13 - polarity 0 means low active, 1 means high active
// R14 - external source with pin held inactive gives no clamp at all
// R15 - host should program clamp delay between 0x10 and 0x20
// R16 - 8-bit gain code maps monotonically 500 mV to 1000 mV full scale
// R17 - 6-bit offset code shifts output by 31 minus code
// R18 - 5-bit phase code delays sample clock in 32 steps of 11.25 degrees
// R19 - inputs sampled on rising sample clock after selected pixel clock plus phase
// R20 - data and both strobes delayed together with the sample clock
// R21 - sample appears on data outputs five clocks after it is taken; code takes five clocks, more when the sink stalls
// R22 - host keeps pll setup bit 7 and bits 1-0 at zero
// R23 - byte registers; new values take effect only at a line boundary; code applies pll setup 0x0c at once, not at the line boundary
`ifndef VDC_DEFINES_VH
`define VDC_DEFINES_VH
`define VDC_ADDR_CLAMP_DELAY 8'h08
`define VDC_ADDR_CLAMP_WIDTH 8'h09
`define VDC_ADDR_CONFIG1 8'h0a
`define VDC_ADDR_PHASE 8'h0b
`define VDC_ADDR_PLL_SETUP 8'h0c
`define VDC_ADDR_STEERING 8'h0d
`define VDC_ADDR_TEST 8'h0f
`define VDC_RST_CLAMP_DELAY 8'h80
`define VDC_RST_CLAMP_WIDTH 8'h80
`define VDC_RST_CONFIG1 8'hf4
`define VDC_RST_PHASE 8'h80
`define VDC_RST_PLL_SETUP 8'h24
`define VDC_RST_STEERING 8'h00
`define VDC_RST_TEST 8'h00
`define VDC_PUMP_HI 4
`define VDC_PUMP_LO 2
`define VDC_VCO_HI 6
`define VDC_VCO_LO 5
`define VDC_REV_HI 3
`define VDC_REV_LO 1
`define VDC_ORDER_BIT 4
`define VDC_CLAMP_POL_BIT 2
`define VDC_CLAMP_SRC_BIT 3
`define VDC_DUAL_BIT 7
`define VDC_PHASE_HI 7
`define VDC_PHASE_LO 3
`define VDC_OFS_HI 7
`define VDC_OFS_LO 2
`define VDC_OFS_MID 7'h1f
`define VDC_LATENCY 5
`define VDC_PHASE_STEPS 32
`endif

// ---- hdl/vdc_fifo.v ----
// parameterised valid/ready fifo for converted samples
`timescale 1ns/100ps
module vdc_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    always @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // vdc_fifo

// ---- hdl/vdc_control.v ----
// digitizer control: register file, clamp timing, phase step, offset, port steering
`timescale 1ns/100ps
`include "vdc_defines.vh"
module vdc_control #(
    parameter REVISION = 3'h1, // arbitrary die revision value
    parameter FIFO_DEPTH = 8
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    input wire hsync_input,
    input wire ext_clamp_pin,
    input wire [7:0] red_sample,
    input wire [7:0] green_sample,
    input wire [7:0] blue_sample,
    input wire [7:0] red_gain_code,
    input wire [7:0] green_gain_code,
    input wire [7:0] blue_gain_code,
    input wire [5:0] red_offset_code,
    input wire [5:0] green_offset_code,
    input wire [5:0] blue_offset_code,
    output reg clamp_active,
    output reg internal_clamp_pulse,
    output reg [2:0] charge_pump_code,
    output reg [10:0] charge_pump_ua,
    output reg [1:0] vco_band,
    output reg [7:0] vco_max_mhz,
    output reg [4:0] phase_code,
    output reg [8:0] phase_deg_x4,
    output reg [9:0] red_range_mv,
    output reg [9:0] green_range_mv,
    output reg [9:0] blue_range_mv,
    output reg [23:0] port_a_data,
    output reg [23:0] port_b_data,
    output reg data_out_strobe,
    output reg data_out_strobe_n,
    input wire sink_ready
);
    // host-side byte registers
    reg [7:0] clamp_delay_q;
    reg [7:0] clamp_width_q;
    reg [7:0] config1_q;
    reg [7:0] phase_q;
    reg [7:0] pll_setup_q;
    reg [7:0] steering_q;
    reg [7:0] test_q;
    // line-safe shadows
    reg [7:0] clamp_delay_s_q;
    reg [7:0] clamp_width_s_q;
    reg [7:0] config1_s_q;
    reg [7:0] steering_s_q;
    reg [4:0] phase_s_q;
    // input synchronisers
    reg hs_m_q;
    reg hs_q;
    reg hs_d1_q;
    reg cl_m_q;
    reg cl_q;
    // clamp state
    reg [1:0] cst_q;
    reg [7:0] ccnt_q;
    // sample path
    reg [4:0] phase_cnt_q;
    reg [23:0] pipe_q [0:`VDC_LATENCY-2];
    reg [`VDC_LATENCY-2:0] pv_q;
    reg odd_q;
    localparam CL_IDLE = 2'b00;
    localparam CL_DELAY = 2'b01;
    localparam CL_PULSE = 2'b10;
    localparam [7:0] PHASE_RST = `VDC_RST_PHASE;
    wire hs_lead;
    wire hs_trail;
    wire samp_en;
    wire [23:0] raw;
    wire [23:0] adj;
    wire fifo_valid;
    wire [23:0] fifo_data;
    wire fifo_pop;
    wire ext_active;
    integer i;

    assign hs_lead = hs_q & ~hs_d1_q;
    assign hs_trail = ~hs_q & hs_d1_q;
    assign raw = {red_sample, green_sample, blue_sample};

    // register writes; test register and reserved bits kept as written
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            clamp_delay_q <= `VDC_RST_CLAMP_DELAY;
            clamp_width_q <= `VDC_RST_CLAMP_WIDTH;
            config1_q <= `VDC_RST_CONFIG1;
            phase_q <= `VDC_RST_PHASE;
            pll_setup_q <= `VDC_RST_PLL_SETUP;
            steering_q <= `VDC_RST_STEERING;
            test_q <= `VDC_RST_TEST;
        end else if (reg_wr) begin
            case (reg_addr)
                `VDC_ADDR_CLAMP_DELAY: clamp_delay_q <= reg_wdata; // R10
                `VDC_ADDR_CLAMP_WIDTH: clamp_width_q <= reg_wdata; // R10
                `VDC_ADDR_CONFIG1: config1_q <= reg_wdata;
                `VDC_ADDR_PHASE: phase_q <= reg_wdata;
                `VDC_ADDR_PLL_SETUP: pll_setup_q <= reg_wdata;
                `VDC_ADDR_STEERING: steering_q <= reg_wdata;
                `VDC_ADDR_TEST: test_q <= reg_wdata;
                default: test_q <= test_q;
            endcase
        end
    end

    // read data and acknowledge; test register never acknowledges
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= (reg_wr | reg_rd) && (reg_addr != `VDC_ADDR_TEST); // R7
            case (reg_addr)
                `VDC_ADDR_CLAMP_DELAY: reg_rdata <= clamp_delay_q;
                `VDC_ADDR_CLAMP_WIDTH: reg_rdata <= clamp_width_q;
                `VDC_ADDR_CONFIG1: reg_rdata <= config1_q;
                `VDC_ADDR_PHASE: reg_rdata <= phase_q;
                `VDC_ADDR_PLL_SETUP: reg_rdata <= pll_setup_q;
                `VDC_ADDR_STEERING: reg_rdata <= {steering_q[7:4], REVISION, steering_q[0]}; // R4
                `VDC_ADDR_TEST: reg_rdata <= test_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // sync pins, two flops each
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hs_m_q <= 1'b0;
            hs_q <= 1'b0;
            hs_d1_q <= 1'b0;
            cl_m_q <= 1'b0;
            cl_q <= 1'b0;
        end else begin
            hs_m_q <= hsync_input;
            hs_q <= hs_m_q;
            hs_d1_q <= hs_q;
            cl_m_q <= ext_clamp_pin;
            cl_q <= cl_m_q;
        end
    end

    // shadow copy at each line start
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            clamp_delay_s_q <= `VDC_RST_CLAMP_DELAY;
            clamp_width_s_q <= `VDC_RST_CLAMP_WIDTH;
            config1_s_q <= `VDC_RST_CONFIG1;
            steering_s_q <= `VDC_RST_STEERING;
            phase_s_q <= PHASE_RST[`VDC_PHASE_HI:`VDC_PHASE_LO];
        end else if (hs_lead) begin // R23
            clamp_delay_s_q <= clamp_delay_q;
            clamp_width_s_q <= clamp_width_q;
            config1_s_q <= config1_q;
            steering_s_q <= steering_q;
            phase_s_q <= phase_q[`VDC_PHASE_HI:`VDC_PHASE_LO];
        end
    end

    // internal clamp: delay after hsync trailing edge, then width pixels
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cst_q <= CL_IDLE;
            ccnt_q <= 8'h00;
            internal_clamp_pulse <= 1'b0;
        end else begin
            case (cst_q)
                CL_IDLE: begin
                    internal_clamp_pulse <= 1'b0;
                    if (hs_trail) begin // R11
                        ccnt_q <= clamp_delay_s_q;
                        cst_q <= CL_DELAY;
                    end
                end
                CL_DELAY: begin
                    if (ccnt_q == 8'h00) begin
                        ccnt_q <= clamp_width_s_q;
                        internal_clamp_pulse <= (clamp_width_s_q != 8'h00); // R11
                        cst_q <= (clamp_width_s_q != 8'h00) ? CL_PULSE : CL_IDLE;
                    end else begin
                        ccnt_q <= ccnt_q - 8'h01;
                    end
                end
                CL_PULSE: begin
                    if (ccnt_q == 8'h01) begin
                        internal_clamp_pulse <= 1'b0;
                        cst_q <= CL_IDLE;
                    end else begin
                        ccnt_q <= ccnt_q - 8'h01;
                    end
                end
                default: begin
                    cst_q <= CL_IDLE;
                    internal_clamp_pulse <= 1'b0;
                end
            endcase
        end
    end

    // external pin honours polarity; inactive pin gives no clamp
    assign ext_active = config1_s_q[`VDC_CLAMP_POL_BIT] ? cl_q : ~cl_q; // R12 R13 R14
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            clamp_active <= 1'b0;
        end else begin
            clamp_active <= config1_s_q[`VDC_CLAMP_SRC_BIT] ? ext_active : internal_clamp_pulse; // R8 R9
        end
    end

    // pll setup decode
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            charge_pump_code <= 3'h0;
            charge_pump_ua <= 11'h000;
            vco_band <= 2'h0;
            vco_max_mhz <= 8'h00;
        end else begin
            charge_pump_code <= pll_setup_q[`VDC_PUMP_HI:`VDC_PUMP_LO]; // R1
            case (pll_setup_q[`VDC_PUMP_HI:`VDC_PUMP_LO]) // R1
                3'h0: charge_pump_ua <= 11'd50;
                3'h1: charge_pump_ua <= 11'd100;
                3'h2: charge_pump_ua <= 11'd150;
                3'h3: charge_pump_ua <= 11'd250;
                3'h4: charge_pump_ua <= 11'd350;
                3'h5: charge_pump_ua <= 11'd500;
                3'h6: charge_pump_ua <= 11'd750;
                default: charge_pump_ua <= 11'd1500;
            endcase
            vco_band <= pll_setup_q[`VDC_VCO_HI:`VDC_VCO_LO]; // R2
            case (pll_setup_q[`VDC_VCO_HI:`VDC_VCO_LO]) // R2
                2'h2: vco_max_mhz <= 8'd120;
                2'h3: vco_max_mhz <= 8'd175;
                default: vco_max_mhz <= 8'd90;
            endcase
        end
    end

    // gain range 500 + code*500/255 mv; product needs 17 bits
    function [9:0] vdc_range;
        input [7:0] g;
        reg [16:0] p;
        begin
            p = ({9'h000, g} * 17'd500) / 17'd255;
            vdc_range = 10'd500 + p[9:0];
        end
    endfunction

    // gain ranges, and phase in 0.75 degree units
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            red_range_mv <= 10'd500;
            green_range_mv <= 10'd500;
            blue_range_mv <= 10'd500;
            phase_code <= 5'h00;
            phase_deg_x4 <= 9'h000;
        end else begin
            red_range_mv <= vdc_range(red_gain_code); // R16
            green_range_mv <= vdc_range(green_gain_code); // R16
            blue_range_mv <= vdc_range(blue_gain_code); // R16
            phase_code <= phase_s_q; // R18
            phase_deg_x4 <= {phase_s_q, 4'h0} - {4'h0, phase_s_q}; // R18
        end
    end

    // sample enable after phase steps from line start
    assign samp_en = (phase_cnt_q == phase_s_q); // R19
    always @(posedge ref_clk) begin
        if (sys_rst || hs_lead) begin
            phase_cnt_q <= 5'h00;
        end else if (!samp_en) begin
            phase_cnt_q <= phase_cnt_q + 5'h01;
        end
    end

    // offset: add 31 minus code, saturating
    function [7:0] vdc_ofs;
        input [7:0] s;
        input [5:0] c;
        reg signed [9:0] t;
        begin
            t = $signed({2'b00, s}) + $signed({3'b000, `VDC_OFS_MID}) - $signed({4'b0000, c});
            if (t < 0) begin
                vdc_ofs = 8'h00;
            end else if (t > 255) begin
                vdc_ofs = 8'hff;
            end else begin
                vdc_ofs = t[7:0];
            end
        end
    endfunction
    assign adj = {vdc_ofs(raw[23:16], red_offset_code), vdc_ofs(raw[15:8], green_offset_code),
        vdc_ofs(raw[7:0], blue_offset_code)}; // R17

    // pipeline plus fifo and port stage give the total latency
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pv_q <= {(`VDC_LATENCY-1){1'b0}};
        end else begin
            pv_q <= {pv_q[`VDC_LATENCY-3:0], samp_en}; // R21
        end
        pipe_q[0] <= adj;
        for (i = 1; i < `VDC_LATENCY - 1; i = i + 1) begin
            pipe_q[i] <= pipe_q[i-1]; // R21
        end
    end

    vdc_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(pv_q[`VDC_LATENCY-2]),
        .in_ready(),
        .in_data(pipe_q[`VDC_LATENCY-2]),
        .out_valid(fifo_valid),
        .out_ready(sink_ready),
        .out_data(fifo_data)
    );
    assign fifo_pop = fifo_valid & sink_ready;

    // port steering and strobes move together with data
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            port_a_data <= 24'h00_0000;
            port_b_data <= 24'h00_0000;
            data_out_strobe <= 1'b0;
            data_out_strobe_n <= 1'b1;
            odd_q <= 1'b1;
        end else begin
            data_out_strobe <= fifo_pop; // R20
            data_out_strobe_n <= ~fifo_pop; // R20
            if (hs_lead) begin
                odd_q <= 1'b1;
            end else if (fifo_pop) begin
                odd_q <= ~odd_q;
            end
            if (fifo_pop) begin
                if (!config1_s_q[`VDC_DUAL_BIT]) begin
                    port_a_data <= fifo_data;
                end else if (odd_q ^ ~steering_s_q[`VDC_ORDER_BIT]) begin // R5
                    port_a_data <= fifo_data;
                end else begin
                    port_b_data <= fifo_data;
                end
            end
        end
    end
endmodule // vdc_control

// ---- bench/vdc_control_chk.sv ----
// concurrent checks on the digitizer control ports
`timescale 1ns/100ps
module vdc_control_chk #(
    parameter REVISION = 3'h1
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_ack,
    input wire [7:0] red_gain_code,
    input wire [2:0] charge_pump_code,
    input wire [10:0] charge_pump_ua,
    input wire [1:0] vco_band,
    input wire [7:0] vco_max_mhz,
    input wire [9:0] red_range_mv,
    input wire data_out_strobe,
    input wire data_out_strobe_n
);
    localparam [87:0] UA_TAB = {11'd1500, 11'd750, 11'd500, 11'd350, 11'd250, 11'd150,
        11'd100, 11'd50};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_wr08;
        reg_wr && !reg_rd && reg_addr == 8'h08;
    endsequence
    sequence s_rd08;
        reg_rd && !reg_wr && reg_addr == 8'h08;
    endsequence
    property p_ack;
        (reg_wr || reg_rd) && reg_addr != 8'h0f |=> reg_ack;
    endproperty
    property p_noack;
        (reg_wr || reg_rd) && reg_addr == 8'h0f |=> !reg_ack;
    endproperty
    property p_wr_rd;
        s_wr08 ##1 s_rd08 |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_rev;
        reg_rd && reg_addr == 8'h0d |=> reg_rdata[3:1] == REVISION;
    endproperty
    property p_pump;
        charge_pump_ua != 0 |-> charge_pump_ua == UA_TAB[charge_pump_code * 11 +: 11];
    endproperty
    property p_vco;
        vco_max_mhz != 0 |-> vco_max_mhz == (vco_band == 2'b11 ? 8'd175 :
            vco_band == 2'b10 ? 8'd120 : 8'd90);
    endproperty
    property p_range;
        $stable(red_gain_code) |=> red_range_mv == 500 + $past(red_gain_code) * 500 / 255;
    endproperty
    property p_strobe_n;
        data_out_strobe_n == !data_out_strobe;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    a_noack: assert property (p_noack) else $error("ack on test register");
    a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
    a_rev: assert property (p_rev) else $error("revision field wrong");
    a_pump: assert property (p_pump) else $error("pump current wrong");
    a_vco: assert property (p_vco) else $error("vco range wrong");
    a_range: assert property (p_range) else $error("gain range wrong");
    a_strobe_n: assert property (p_strobe_n) else $error("strobes not paired");
endmodule // vdc_control_chk
bind vdc_control vdc_control_chk #(.REVISION(REVISION)) u_vdc_chk (.ref_clk, .sys_rst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .red_gain_code,
    .charge_pump_code, .charge_pump_ua, .vco_band, .vco_max_mhz, .red_range_mv,
    .data_out_strobe, .data_out_strobe_n);

// ---- bench/vdc_sink_model.sv ----
// downstream sink: ready is the inverse of stall registered on the falling clock edge, captures strobed port words
`timescale 1ns/100ps
module vdc_sink_model (
    input wire ref_clk,
    input wire stall,
    input wire data_out_strobe,
    input wire [23:0] port_a_data,
    input wire [23:0] port_b_data,
    output reg sink_ready
);
    logic [23:0] got_a[$];
    logic [23:0] got_b[$];
    always @(negedge ref_clk) begin
        sink_ready <= !stall;
    end
    always @(posedge ref_clk) begin
        if (data_out_strobe === 1'b1) begin
            got_a.push_back(port_a_data);
            got_b.push_back(port_b_data);
        end
    end
endmodule // vdc_sink_model

// ---- bench/test_video_digitizer_control.sv ----
// self-checking bench for the digitizer control
`timescale 1ns/100ps
module test_video_digitizer_control;
    localparam [2:0] DIE_REVISION = 3'h5; // arbitrary revision value
    localparam integer LINE = 80;
    reg ref_clk, sys_rst, reg_wr, reg_rd, hsync_input, ext_clamp_pin, stall, stall_en;
    reg [7:0] reg_addr, reg_wdata, smp_r, smp_g, smp_b, gain, d;
    reg [5:0] ofs;
    wire [7:0] reg_rdata, vco_max_mhz;
    wire reg_ack, clamp_active, internal_clamp_pulse, data_out_strobe, sink_ready;
    wire [2:0] charge_pump_code;
    wire [1:0] vco_band;
    wire [4:0] phase_code;
    wire [10:0] charge_pump_ua;
    wire [9:0] green_range_mv;
    wire [8:0] phase_deg_x4;
    wire [23:0] port_a_data, port_b_data;
    integer failures, cmp_count, i, t, seed, np, nc, st;
    int ua_tab[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};

    vdc_control #(.REVISION(DIE_REVISION)) DUT (.ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_ack, .hsync_input, .ext_clamp_pin, .red_sample(smp_r),
        .green_sample(smp_g), .blue_sample(smp_b), .red_gain_code(gain),
        .green_gain_code(gain), .blue_gain_code(gain), .red_offset_code(ofs),
        .green_offset_code(ofs), .blue_offset_code(ofs), .clamp_active,
        .internal_clamp_pulse, .charge_pump_code, .charge_pump_ua, .vco_band, .vco_max_mhz,
        .phase_code, .phase_deg_x4, .red_range_mv(), .green_range_mv, .blue_range_mv(),
        .port_a_data, .port_b_data, .data_out_strobe, .data_out_strobe_n(), .sink_ready);
    vdc_sink_model m (.ref_clk, .stall, .data_out_strobe, .port_a_data, .port_b_data,
        .sink_ready);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        t <= (t == LINE - 1) ? 0 : t + 1;
        hsync_input <= (t < 8);
        stall <= stall_en && (($random(seed) & 1) == 1);
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] v, input logic ack_exp);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        chk("write ack", ack_exp, reg_ack);
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("read data", e, reg_rdata);
        chk("read ack", 1, reg_ack);
    endtask
    task lines(input integer k);
        repeat (k * LINE) @(negedge ref_clk);
    endtask
    task scan;
        integer n;
        np = 0;
        nc = 0;
        st = -1;
        for (n = 0; t != 0; n = n + 1) begin
            @(negedge ref_clk);
            if (n > 2 * LINE) begin
                failures = failures + 1;
                close_out;
            end
        end
        for (n = 0; n < LINE; n = n + 1) begin
            @(negedge ref_clk);
            if (internal_clamp_pulse === 1'b1 && st < 0) st = n;
            if (internal_clamp_pulse === 1'b1) np = np + 1;
            if (clamp_active === 1'b1) nc = nc + 1;
        end
    endtask
    function [7:0] ch(input [7:0] s);
        ch = s + 8'd31 - {2'b00, ofs};
    endfunction

    initial begin
        failures = 0;
        cmp_count = 0;
        t = 0;
        seed = 14;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        hsync_input = 1'b0;
        ext_clamp_pin = 1'b1;
        stall_en = 1'b0;
        smp_r = 8'h40;
        smp_g = 8'h40;
        smp_b = 8'h40;
        gain = 8'h66;
        ofs = 6'h1f;
        repeat (8) @(negedge ref_clk);
        sys_rst = 1'b0;
        rdc(8'h08, 8'h80);
        rdc(8'h09, 8'h80);
        rdc(8'h0a, 8'hf4);
        rdc(8'h0b, 8'h80);
        rdc(8'h0c, 8'h24);
        rdc(8'h0d, {4'h0, DIE_REVISION, 1'b0});
        wr(8'h0f, 8'h00, 1'b0);
        rdc(8'h20, 8'h00);
        wr(8'h20, 8'h5a, 1'b1);
        wr(8'h0d, 8'h1e, 1'b1);
        rdc(8'h0d, {4'h1, DIE_REVISION, 1'b0});
        @(negedge ref_clk);
        d = $random(seed);
        reg_wr = 1'b1;
        reg_addr = 8'h08;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("back to back read", d, reg_rdata);
        $display("register test done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h0c, {1'b0, i[1:0], i[2:0], 2'b00}, 1'b1);
            lines(2);
            chk("pump code", i, charge_pump_code);
            chk("pump current", ua_tab[i], charge_pump_ua);
            chk("vco band", i[1:0], vco_band);
            chk("vco max", i[1] ? (i[0] ? 175 : 120) : 90, vco_max_mhz);
        end
        wr(8'h0b, 8'hf8, 1'b1);
        lines(2);
        chk("phase code", 31, phase_code);
        chk("phase step", 31 * 15, phase_deg_x4);
        $display("pll and phase test done");
        wr(8'h08, 8'h10, 1'b1);
        wr(8'h09, 8'h06, 1'b1);
        wr(8'h0a, 8'h74, 1'b1);
        lines(2);
        scan;
        chk("pulse width", 6, np);
        chk("clamp width", 6, nc);
        chk("pulse start", 1, st >= 24 && st <= 34);
        for (i = 0; i < 4; i = i + 1) begin
            ext_clamp_pin = i[0];
            wr(8'h0a, {5'b01111, i[1], 2'b00}, 1'b1);
            lines(2);
            scan;
            chk("ext clamp", (i[0] == i[1]) ? LINE : 0, nc);
        end
        $display("clamp test done");
        for (i = 0; i < 6; i = i + 1) begin
            ofs = (i % 3 == 0) ? 6'h00 : (i % 3 == 1) ? 6'h1f : 6'h3f;
            stall_en = (i >= 3);
            smp_r = 8'h30 + ($random(seed) & 8'h3f);
            smp_g = 8'h30 + ($random(seed) & 8'h3f);
            smp_b = 8'h30 + ($random(seed) & 8'h3f);
            gain = $random(seed);
            wr(8'h0d, (i == 4) ? 8'h00 : 8'h1e, 1'b1);
            wr(8'h0a, (i < 3) ? 8'h74 : 8'hf4, 1'b1);
            lines(3);
            m.got_a.delete();
            m.got_b.delete();
            lines(2);
            chk("words seen", 1, m.got_a.size() > 0);
            chk("green range", 500 + gain * 500 / 255, green_range_mv);
            while (m.got_a.size() > 0) begin
                chk("port a", {ch(smp_r), ch(smp_g), ch(smp_b)}, m.got_a.pop_front());
                d = (i < 3) ? 8'h00 : 8'h01;
                if (d == 8'h01) chk("port b", {ch(smp_r), ch(smp_g), ch(smp_b)}, m.got_b[0]);
                m.got_b.delete(0);
            end
        end
        $display("data path test done");
        close_out;
    end
endmodule // test_video_digitizer_control
